// File: pkg/cvp_pkg.sv
// Function
// - thresholds are 12-bit codes, 0 to 4.8 V
// - hard overvoltage above threshold, default 4.35 V
// - hard overvoltage needs five consecutive scans over
// - hard undervoltage below threshold, default 1.8 V
// - hard undervoltage needs five consecutive scans under
// - hard undervoltage releases above undervoltage recovery level
// - overvoltage above threshold, default 4.25 V
// - overvoltage clears below recovery, default 4.15 V
// - one timer qualifies overvoltage set and clear
// - undervoltage below threshold, default 2.7 V
// - undervoltage clears above recovery, default 3.0 V
// - undervoltage detection qualified by programmable timer
// - undervoltage release takes timer plus two seconds
// - sleep detected below threshold, default 2.0 V
// - sleep detection qualified by programmable timer
// - precharge below threshold, 117 mV hysteresis out
package cvp_pkg;
    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam int CVP_NUM_THR = 8;
    localparam int CVP_NUM_TMR = 3;
    localparam logic [7:0] CVP_THR_BASE = 8'h00;
    localparam logic [7:0] CVP_TMR_BASE = 8'h20;
    localparam logic [7:0] CVP_STATUS = 8'h2c;
    localparam logic [3:0] CVP_LAST_INDEX = 4'hb;
    // threshold indices
    localparam int CVP_T_HOV = 0;
    localparam int CVP_T_HUV = 1;
    localparam int CVP_T_OV = 2;
    localparam int CVP_T_OVR = 3;
    localparam int CVP_T_UV = 4;
    localparam int CVP_T_UVR = 5;
    localparam int CVP_T_SLP = 6;
    localparam int CVP_T_PRE = 7;
    // timer indices
    localparam int CVP_C_OV = 0;
    localparam int CVP_C_UV = 1;
    localparam int CVP_C_SLP = 2;
    // ************************************************************
    // reset values and field layout
    // ************************************************************
    localparam logic [11:0] CVP_THR_RST [CVP_NUM_THR] = '{
        12'he80, 12'h600, 12'he2a, 12'hdd5,
        12'h900, 12'ha00, 12'h6aa, 12'h7aa};
    localparam logic [10:0] CVP_TMR_RST = 11'h201;
    localparam int CVP_TMR_UNIT_BIT = 9;
    localparam int CVP_TMR_HI_BIT = 10;
    // status bit positions
    localparam int CVP_S_HOV = 0;
    localparam int CVP_S_HUV = 1;
    localparam int CVP_S_OV = 2;
    localparam int CVP_S_UV = 3;
    localparam int CVP_S_SLP = 4;
    localparam int CVP_S_PRE = 5;
    // ************************************************************
    // counts and timing
    // ************************************************************
    localparam logic [2:0] CVP_LOCKOUT_SAMPLES = 3'h5;
    localparam logic [12:0] CVP_PRE_HYST = 13'h064; // 117 mV in lsbs
    localparam logic [1:0] CVP_UV_RELEASE_EXTRA_S = 2'h2;
    localparam int CVP_CLK_PERIOD_NS = 10;
    localparam int CVP_MS_PERIOD_NS = 1000000;
    localparam int CVP_MS_CYCLES = CVP_MS_PERIOD_NS / CVP_CLK_PERIOD_NS;
    localparam logic [9:0] CVP_MS_PER_S = 10'h3e8;
    // timer phases
    typedef enum logic [2:0]
    {
        CVP_PH_IDLE = 3'h1,
        CVP_PH_BASE = 3'h2,
        CVP_PH_EXTRA = 3'h4
    } cvp_phase_t;
endpackage : cvp_pkg

// File: logic/cvp_cell_voltage_protection.sv
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cvp_cell_voltage_protection
#(
    parameter int MS_CYCLES = cvp_pkg::CVP_MS_CYCLES
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // cell samples from the measurement front end
    input wire logic sample_valid,
    input wire logic [11:0] cell_code,
    input wire logic scan_done,
    // protection flags
    output logic hard_overvoltage,
    output logic hard_undervoltage,
    output logic overvoltage,
    output logic undervoltage,
    output logic sleep_detect,
    output logic precharge_select
);
    localparam int MSW = $clog2(MS_CYCLES);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (MS_CYCLES < 2)
    begin : g_bad_ms
        $error("MS_CYCLES must be at least 2");
    end

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic [9:0] tmr_count(input logic [10:0] code);
        tmr_count = {code[cvp_pkg::CVP_TMR_HI_BIT], code[8:0]};
    endfunction : tmr_count

    function automatic logic addr_ok(input logic [31:0] a);
        addr_ok = (a[31:6] == 26'h0) && (a[1:0] == 2'h0)
            && (a[5:2] <= cvp_pkg::CVP_LAST_INDEX);
    endfunction : addr_ok

    // ************************************************************
    // register file
    // ************************************************************
    logic [11:0] thr [cvp_pkg::CVP_NUM_THR];
    logic [10:0] tmr [cvp_pkg::CVP_NUM_TMR];
    logic wr_pend;
    logic [3:0] wr_idx;
    logic [5:0] status;
    logic take;
    logic [3:0] a_idx;

    assign take = hsel && htrans[1] && hready;
    assign a_idx = haddr[5:2];

    // zero wait state, always okay
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // write capture in address phase, commit in data phase
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wr_pend <= 1'b0;
            wr_idx <= 4'h0;
        end
        else
        begin
            wr_pend <= take && hwrite && addr_ok(haddr);
            wr_idx <= a_idx;
        end
    end

    // thresholds and timers; unmapped writes vanish
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < cvp_pkg::CVP_NUM_THR; i++)
                thr[i] <= cvp_pkg::CVP_THR_RST[i];
            for (int i = 0; i < cvp_pkg::CVP_NUM_TMR; i++)
                tmr[i] <= cvp_pkg::CVP_TMR_RST;
        end
        else if (wr_pend)
        begin
            if (wr_idx < 4'(cvp_pkg::CVP_NUM_THR))
                thr[wr_idx[2:0]] <= hwdata[11:0];
            else if (wr_idx < 4'(cvp_pkg::CVP_TMR_BASE[7:2] + 6'h3))
                tmr[2'(wr_idx - 4'h8)] <= hwdata[10:0];
        end
    end

    // read data is ready for the data phase
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            hrdata <= 32'h0;
        else if (take && !hwrite && addr_ok(haddr))
        begin
            if (a_idx < 4'h8)
                hrdata <= {20'h0, thr[a_idx[2:0]]};
            else if (a_idx < 4'hb)
                hrdata <= {21'h0, tmr[2'(a_idx - 4'h8)]};
            else
                hrdata <= {26'h0, status};
        end
        else
            hrdata <= 32'h0;
    end

    // ************************************************************
    // per-scan comparison
    // ************************************************************
    // bit order: any>hov, any<huv, any>ov, all<ovr, any<uv,
    // all>uvr, any<sleep, any<pre, all>pre+hyst
    logic [8:0] acc;
    logic [8:0] next_acc;
    logic [8:0] samp;
    logic [8:0] res;
    logic [12:0] pre_hi;

    assign pre_hi = {1'b0, thr[cvp_pkg::CVP_T_PRE]} + cvp_pkg::CVP_PRE_HYST;

    // "all" bits start at one, "any" bits at zero
    always_comb
    begin
        samp[0] = cell_code > thr[cvp_pkg::CVP_T_HOV];
        samp[1] = cell_code < thr[cvp_pkg::CVP_T_HUV];
        samp[2] = cell_code > thr[cvp_pkg::CVP_T_OV];
        samp[3] = cell_code < thr[cvp_pkg::CVP_T_OVR];
        samp[4] = cell_code < thr[cvp_pkg::CVP_T_UV];
        samp[5] = cell_code > thr[cvp_pkg::CVP_T_UVR];
        samp[6] = cell_code < thr[cvp_pkg::CVP_T_SLP];
        samp[7] = cell_code < thr[cvp_pkg::CVP_T_PRE];
        samp[8] = {1'b0, cell_code} > pre_hi;
        next_acc = acc;
        if (sample_valid)
        begin
            next_acc = acc | (samp & 9'h0d7);
            next_acc = next_acc & (samp | 9'h0d7);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            acc <= 9'h128;
            res <= 9'h000;
        end
        else if (scan_done)
        begin
            acc <= 9'h128;
            res <= next_acc;
        end
        else
            acc <= next_acc;
    end

    // ************************************************************
    // lockouts and precharge, decided per scan
    // ************************************************************
    logic [2:0] hov_cnt;
    logic [2:0] huv_cnt;

    // ~32 ms per scan: five scans give the 160-192 ms window
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            hov_cnt <= 3'h0;
            huv_cnt <= 3'h0;
            hard_overvoltage <= 1'b0;
            hard_undervoltage <= 1'b0;
            precharge_select <= 1'b0;
        end
        else if (scan_done)
        begin
            if (!next_acc[0])
                hov_cnt <= 3'h0;
            else if (hov_cnt < cvp_pkg::CVP_LOCKOUT_SAMPLES)
                hov_cnt <= hov_cnt + 3'h1;
            if (!next_acc[1])
                huv_cnt <= 3'h0;
            else if (huv_cnt < cvp_pkg::CVP_LOCKOUT_SAMPLES)
                huv_cnt <= huv_cnt + 3'h1;
            if (next_acc[0] && hov_cnt == cvp_pkg::CVP_LOCKOUT_SAMPLES - 3'h1)
                hard_overvoltage <= 1'b1;
            else if (next_acc[3])
                hard_overvoltage <= 1'b0;
            if (next_acc[1] && huv_cnt == cvp_pkg::CVP_LOCKOUT_SAMPLES - 3'h1)
                hard_undervoltage <= 1'b1;
            else if (next_acc[5])
                hard_undervoltage <= 1'b0;
            if (next_acc[7])
                precharge_select <= 1'b1;
            else if (next_acc[8])
                precharge_select <= 1'b0;
        end
    end

    // ************************************************************
    // time base
    // ************************************************************
    logic [MSW-1:0] ms_div;
    logic [9:0] s_div;
    logic ms_tick;
    logic s_tick;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ms_div <= '0;
            s_div <= 10'h0;
            ms_tick <= 1'b0;
            s_tick <= 1'b0;
        end
        else
        begin
            ms_tick <= ms_div == MSW'(MS_CYCLES - 1);
            s_tick <= (ms_div == MSW'(MS_CYCLES - 1))
                && (s_div == cvp_pkg::CVP_MS_PER_S - 10'h1);
            if (ms_div == MSW'(MS_CYCLES - 1))
            begin
                ms_div <= '0;
                if (s_div == cvp_pkg::CVP_MS_PER_S - 10'h1)
                    s_div <= 10'h0;
                else
                    s_div <= s_div + 10'h1;
            end
            else
                ms_div <= ms_div + MSW'(1);
        end
    end

    // ************************************************************
    // qualified flags: ov, uv, sleep
    // ************************************************************
    logic [2:0] flag;
    logic [2:0] det;
    logic [2:0] rel;
    logic [2:0] timed_rel;

    // sleep leaves at once; ov and uv release through their timers
    assign det = {res[6], res[4], res[2]};
    assign rel = {~res[6], res[5], res[3]};
    assign timed_rel = 3'b011;

    for (genvar c = 0; c < cvp_pkg::CVP_NUM_TMR; c++)
    begin : g_chan
        cvp_pkg::cvp_phase_t phase;
        logic [9:0] cnt;
        logic [1:0] ecnt;
        logic cond;
        logic [9:0] base;
        logic [1:0] extra;
        logic unit_tick;
        logic chan_flag;

        // one driver per channel; the vector only gathers them
        assign flag[c] = chan_flag;
        assign cond = flag[c] ? rel[c] : det[c];
        assign base = (flag[c] && !timed_rel[c]) ? 10'h0
            : tmr_count(tmr[c]);
        assign extra = (c == cvp_pkg::CVP_C_UV && flag[c])
            ? cvp_pkg::CVP_UV_RELEASE_EXTRA_S : 2'h0;
        assign unit_tick = tmr[c][cvp_pkg::CVP_TMR_UNIT_BIT]
            ? s_tick : ms_tick;

        // count while the condition holds, restart when it drops
        always_ff @(posedge ref_clk)
        begin
            if (rst)
            begin
                phase <= cvp_pkg::CVP_PH_IDLE;
                cnt <= 10'h0;
                ecnt <= 2'h0;
                chan_flag <= 1'b0;
            end
            else if (!cond)
            begin
                phase <= cvp_pkg::CVP_PH_IDLE;
                cnt <= 10'h0;
                ecnt <= 2'h0;
            end
            else
            begin
                case (phase)
                    cvp_pkg::CVP_PH_IDLE:
                    begin
                        cnt <= 10'h0;
                        ecnt <= 2'h0;
                        if (base != 10'h0)
                            phase <= cvp_pkg::CVP_PH_BASE;
                        else if (extra != 2'h0)
                            phase <= cvp_pkg::CVP_PH_EXTRA;
                        else
                            chan_flag <= !chan_flag;
                    end
                    cvp_pkg::CVP_PH_BASE:
                    begin
                        if (unit_tick)
                        begin
                            cnt <= cnt + 10'h1;
                            if (cnt + 10'h1 >= base)
                            begin
                                if (extra != 2'h0)
                                    phase <= cvp_pkg::CVP_PH_EXTRA;
                                else
                                begin
                                    phase <= cvp_pkg::CVP_PH_IDLE;
                                    chan_flag <= !chan_flag;
                                end
                            end
                        end
                    end
                    cvp_pkg::CVP_PH_EXTRA:
                    begin
                        if (s_tick)
                        begin
                            ecnt <= ecnt + 2'h1;
                            if (ecnt + 2'h1 >= extra)
                            begin
                                phase <= cvp_pkg::CVP_PH_IDLE;
                                chan_flag <= !chan_flag;
                            end
                        end
                    end
                    default:
                        phase <= cvp_pkg::CVP_PH_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // flag outputs and status
    // ************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            overvoltage <= 1'b0;
            undervoltage <= 1'b0;
            sleep_detect <= 1'b0;
        end
        else
        begin
            overvoltage <= flag[cvp_pkg::CVP_C_OV];
            undervoltage <= flag[cvp_pkg::CVP_C_UV];
            sleep_detect <= flag[cvp_pkg::CVP_C_SLP];
        end
    end

    assign status = {precharge_select, sleep_detect, undervoltage,
        overvoltage, hard_undervoltage, hard_overvoltage};
endmodule : cvp_cell_voltage_protection
`default_nettype wire

// File: testbench/cvp_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cvp_sva
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // cell link and flags
    input wire logic scan_done,
    input wire logic hard_overvoltage,
    input wire logic hard_undervoltage,
    input wire logic undervoltage,
    input wire logic precharge_select
);
    // ********************
    // helpers
    // ********************
    logic rd_phase;
    logic [2:0] scans;
    // read data phase follows an accepted read
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rd_phase <= 1'b0;
        else if (hready)
            rd_phase <= hsel && htrans[1] && !hwrite;
    end
    // scans since reset, saturates: lockouts need five
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            scans <= 3'h0;
        else if (scan_done && scans != 3'h7)
            scans <= scans + 3'h1;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    AST_HOV_AT_SCAN: assert property (
        $changed(hard_overvoltage) |-> $past(scan_done))
        else $error("hard overvoltage moved off a scan end");
    AST_HOV_FIVE: assert property (
        $rose(hard_overvoltage) |-> scans >= 3'h5)
        else $error("hard overvoltage before five scans");
    AST_HUV_AT_SCAN: assert property (
        $changed(hard_undervoltage) |-> $past(scan_done))
        else $error("hard undervoltage moved off a scan end");
    AST_HUV_FIVE: assert property (
        $rose(hard_undervoltage) |-> scans >= 3'h5)
        else $error("hard undervoltage before five scans");
    AST_PRE_AT_SCAN: assert property (
        $changed(precharge_select) |-> $past(scan_done))
        else $error("precharge moved off a scan end");
    AST_UV_HOLD: assert property (
        $rose(undervoltage) |=> undervoltage [*8])
        else $error("undervoltage released too soon");
    AST_RD_WIDTH: assert property (
        hrdata[31:12] == 20'h0)
        else $error("read data wider than a code");
    AST_RD_IDLE: assert property (
        !rd_phase |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    AST_BUS_OKAY: assert property (
        hreadyout && !hresp)
        else $error("bus not ready or not okay");
endmodule : cvp_sva
`default_nettype wire

// File: testbench/cvp_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module cvp_front_end
(
    // cell link to the block
    input wire logic ref_clk,
    output logic sample_valid,
    output logic [11:0] cell_code,
    output logic scan_done
);
    // idle link; code toggles so stale data never looks valid
    initial
    begin
        sample_valid = 1'b0;
        scan_done = 1'b0;
        cell_code = 12'h5a5;
    end
    // two cells per scan, then a quiet gap of any length
    task automatic scan(input logic [11:0] a, b, input int gap);
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        cell_code <= a;
        @(posedge ref_clk);
        cell_code <= b;
        scan_done <= 1'b1;
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        scan_done <= 1'b0;
        cell_code <= ~b;
        repeat (gap) @(posedge ref_clk) cell_code <= ~cell_code;
    endtask : scan
endmodule : cvp_front_end
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk, rst, hsel, hwrite, hreadyout, hresp, rd_dphase;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic sample_valid, scan_done;
    logic [11:0] cell_code;
    logic [5:0] flags;
    logic [31:0] exp_q[$];
    int errors, num_checks;
    // ********************
    // harness
    // ********************
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // 4 cycles per ms keeps a second at 4000 cycles
    cvp_cell_voltage_protection #(.MS_CYCLES(4)) DUT
    (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sample_valid(sample_valid),
        .cell_code(cell_code), .scan_done(scan_done),
        .hard_overvoltage(flags[0]), .hard_undervoltage(flags[1]),
        .overvoltage(flags[2]), .undervoltage(flags[3]),
        .sleep_detect(flags[4]), .precharge_select(flags[5])
    );
    cvp_front_end fe
    (
        .ref_clk(ref_clk), .sample_valid(sample_valid),
        .cell_code(cell_code), .scan_done(scan_done)
    );
    task automatic check(input string name, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // read data stands one cycle only, compare it there
    always @(posedge ref_clk)
    begin
        if (rd_dphase && hreadyout)
            check("hrdata", hrdata, exp_q.pop_front());
        if (hreadyout)
            rd_dphase <= hsel && htrans[1] && !hwrite;
    end
    // single word transfer; a read notes its expectation
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        if (!w)
            exp_q.push_back(d);
        do @(posedge ref_clk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0;
        do @(posedge ref_clk); while (!hreadyout);
    endtask : bus
    task automatic st(input logic [31:0] e);
        bus(8'h2c, 1'b0, e);
        check("flags", {26'h0, flags}, e);
    endtask : st
    task automatic reset_dut();
        rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
    endtask : reset_dut
    // 10 ms timers so detection fits a short run
    task automatic fast_timers();
        for (int i = 0; i < 3; i++)
            bus(8'h20 + 8'(4 * i), 1'b1, 32'h00a);
    endtask : fast_timers
    task automatic scans(input int n, input logic [11:0] a, b);
        repeat (n) fe.scan(a, b, 3);
    endtask : scans
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        errors++;
        wrap_up();
    end
    // ********************
    // scenarios
    // ********************
    initial
    begin
        {rst, hsel, haddr, htrans, hwrite, hwdata, rd_dphase} = '0;
        hsize = 3'b010;
        v = $urandom(65195);
        reset_dut();
        for (int i = 0; i < 8; i++)
            bus(8'(4 * i), 1'b0, {20'h0, cvp_pkg::CVP_THR_RST[i]});
        for (int i = 0; i < 3; i++)
            bus(8'h20 + 8'(4 * i), 1'b0, {21'h0, cvp_pkg::CVP_TMR_RST});
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom;
            bus(8'(4 * i), 1'b1, v);
            bus(8'(4 * i), 1'b0, {20'h0, v[11:0]});
        end
        bus(8'h24, 1'b1, v);
        bus(8'h24, 1'b0, {21'h0, v[10:0]});
        bus(8'h2c, 1'b1, 32'hffffffff);
        st(32'h0);
        bus(8'h30, 1'b1, v);
        bus(8'h30, 1'b0, 32'h0);
        reset_dut();
        scans(4, 12'he81, 12'ha01);
        scans(1, 12'he80, 12'ha01);
        scans(4, 12'he81, 12'ha01);
        st(32'h00);
        scans(1, 12'he81, 12'ha01);
        st(32'h01);
        scans(1, 12'hdd5, 12'hdd4);
        st(32'h01);
        scans(1, 12'hdd4, 12'ha01);
        st(32'h00);
        scans(4, 12'h5ff, 12'ha01);
        st(32'h20);
        scans(1, 12'h5ff, 12'ha01);
        st(32'h22);
        scans(1, 12'ha00, 12'ha01);
        st(32'h02);
        scans(1, 12'ha01, 12'ha01);
        st(32'h00);
        scans(1, 12'h7a9, 12'ha01);
        st(32'h20);
        scans(1, 12'h80e, 12'h80e);
        st(32'h20);
        scans(1, 12'h80f, 12'h80f);
        st(32'h00);
        // a dip to the threshold must restart the count
        reset_dut();
        fast_timers();
        scans(4, 12'he2b, 12'ha01);
        scans(1, 12'he2a, 12'ha01);
        scans(4, 12'he2b, 12'ha01);
        st(32'h00);
        scans(10, 12'he2b, 12'ha01);
        st(32'h04);
        scans(10, 12'hdd5, 12'ha01);
        st(32'h04);
        scans(2, 12'hdd4, 12'ha01);
        st(32'h04);
        scans(10, 12'hdd4, 12'ha01);
        st(32'h00);
        reset_dut();
        fast_timers();
        fe.scan(12'h900, 12'ha01, 60);
        st(32'h00);
        fe.scan(12'h8ff, 12'ha01, 3);
        st(32'h00);
        fe.scan(12'h8ff, 12'ha01, 60);
        st(32'h08);
        fe.scan(12'ha01, 12'ha01, 3000);
        st(32'h08);
        fe.scan(12'ha01, 12'ha01, 12000);
        st(32'h00);
        reset_dut();
        fast_timers();
        fe.scan(12'h6aa, 12'ha01, 60);
        st(32'h28);
        fe.scan(12'h6a9, 12'ha01, 3);
        st(32'h28);
        fe.scan(12'h6a9, 12'ha01, 60);
        st(32'h38);
        fe.scan(12'ha01, 12'ha01, 3);
        st(32'h08);
        @(posedge ref_clk);
        check("pending", 32'(exp_q.size()), 32'h0);
        wrap_up();
    end
endmodule : testbench
bind cvp_cell_voltage_protection cvp_sva u_sva
(
    .ref_clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .hrdata, .scan_done, .hard_overvoltage,
    .hard_undervoltage, .undervoltage, .precharge_select
);
`default_nettype wire
